// ---- hdl/dop_pkg.sv ----
// package: constants and types for the dual output pwm unit
package dop_pkg;
  // ----------------------------------------------------------------
  // register index map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_MODE_SELECT = 4'h1;
  localparam logic [3:0] ADDR_OUTPUT_LEVEL = 4'h2;
  localparam logic [3:0] ADDR_MAIN_PERIOD = 4'h3;
  localparam logic [3:0] ADDR_EDGE_OFFSET = 4'h4;
  localparam logic [3:0] ADDR_CMP0 = 4'h5;
  localparam logic [3:0] ADDR_CMP1 = 4'h6;
  localparam logic [3:0] ADDR_CMP2 = 4'h7;
  localparam logic [3:0] ADDR_MOD_PERIOD = 4'h8;
  localparam logic [3:0] ADDR_MOD_COMPARE = 4'h9;
  localparam logic [3:0] ADDR_MAIN_TIMER = 4'ha;
  localparam logic [3:0] ADDR_MOD_TIMER = 4'hb;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  // ----------------------------------------------------------------
  // timer control field positions
  // ----------------------------------------------------------------
  localparam int TC_MAIN_RUN = 0;
  localparam int TC_MAIN_CENTER = 1;
  localparam int TC_MAIN_DIV_LSB = 2;
  localparam int TC_MOD_RUN = 5;
  localparam int TC_MOD_DIV_LSB = 6;
  localparam int TC_MOD_OUT_EN = 9;
  localparam int TC_MOD_INVERT = 10;
  localparam int TC_TRAP_EN = 11;
  // mode select: four bits per channel, bit 3 is the burst enable
  localparam int MS_BURST_BIT = 3;
  // output level control: bits 0..2 primary, 3..5 compl, 6 modulator
  localparam int OL_COMPL_LSB = 3;
  localparam int OL_MOD_BIT = 6;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_TIMER_CONTROL = 16'h0000;
  localparam logic [11:0] RST_MODE_SELECT = 12'h000;
  localparam logic [6:0] RST_OUTPUT_LEVEL = 7'h00;
  localparam logic [15:0] RST_MAIN_PERIOD = 16'hffff;
  localparam logic [9:0] RST_MOD_PERIOD = 10'h3ff;
  // least period of two timer ticks: period value at least one
  localparam logic [15:0] MIN_PERIOD_VALUE = 16'h0001;
  // channel pin allocation codes
  typedef enum logic [2:0] {
    DOP_SEL_OFF = 3'b000,
    DOP_SEL_PRIMARY = 3'b001,
    DOP_SEL_COMPL = 3'b010,
    DOP_SEL_BOTH = 3'b011
  } dop_sel_t;
  // output pin group
  typedef struct packed {
    logic [2:0] primary;
    logic [2:0] compl;
    logic modulator;
  } dop_pins_t;
endpackage

// ---- hdl/dop_unit.sv ----
// dual output pwm unit: main timer, three channels, modulator channel
//
// Summary of operation
// - software picks passive level per output
// - trap input forces outputs to latch levels
// - level changes take effect at once
// - modulator signal gates complementary outputs, optionally inverted
// - modulator pin driven only when enabled
// - edge mode: match makes output active
// - at period: clear timer, outputs passive
// - duty 0..100 percent, pin selection field
// - complementary compares timer plus offset
// - compl 0% above period+offset, 100% at offset
// - offset only on the three main channels
// - center mode only on the main timer
// - center: up active, down passive on match
// - center compl edges shifted by offset
// - output period at least two ticks
// - prescaler divides clock by 1 to 128
// - edge period is period value plus one
// - modulator timer: one output, edge only
// - burst gates only complementary active phases
// - burst enable bit per channel
// - main timer 16 bits, modulator 10 bits
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module dop_unit
  import dop_pkg::*;
#(
  parameter int MAIN_W = 16, // main timer width
  parameter int MOD_W = 10 // modulator timer width
) (
  input wire logic core_clk_i, // 100 MHz clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [3:0] addr_i, // register index
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [15:0] rdata_o, // read data, cycle after strobe
  input wire logic trap_n_i, // emergency input, active low
  input wire logic [6:0] trap_level_i, // port output latch levels
  output dop_pins_t pins_o // pwm pins
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] timer_control_reg; // run, mode, divider, enables
  logic [11:0] mode_select_reg; // per-channel select + burst
  logic [6:0] output_level_control; // passive level per pin
  logic [MAIN_W-1:0] main_period_value; // main period
  logic [MAIN_W-1:0] edge_offset_value; // shared offset
  logic [MAIN_W-1:0] channel_compare_value [3]; // per channel
  logic [MOD_W-1:0] timer_period_value; // modulator period
  logic [MOD_W-1:0] modulator_compare_value; // modulator compare
  logic [MAIN_W-1:0] main_timer; // main counter
  logic main_down_reg; // center mode direction
  logic [MOD_W-1:0] modulator_timer; // modulator counter
  logic [6:0] prescale_reg; // free prescaler
  logic [2:0] prim_state_reg; // primary active state
  logic [2:0] compl_state_reg; // complementary active state
  logic mod_state_reg; // modulator active state
  logic [15:0] rdata_reg; // read data
  dop_pins_t pins_reg; // output flops

  // ----------------------------------------------------------------
  // prescaler tick enables
  // ----------------------------------------------------------------
  wire [2:0] main_div = timer_control_reg[TC_MAIN_DIV_LSB +: 3];
  wire [2:0] mod_div = timer_control_reg[TC_MOD_DIV_LSB +: 3];
  wire [7:0] div_taps = {prescale_reg, 1'b1} + 8'h00;
  wire [7:0] tap_mask_main = 8'h01 << main_div;
  wire [7:0] tap_mask_mod = 8'h01 << mod_div;
  // tick when all prescaler bits below the tap are ones
  wire [7:0] all_ones = {1'b1, prescale_reg};
  wire main_tick = timer_control_reg[TC_MAIN_RUN] &
                   (((tap_mask_main - 8'h01) & ~all_ones) == 8'h00);
  wire mod_tick = timer_control_reg[TC_MOD_RUN] &
                  (((tap_mask_mod - 8'h01) & ~all_ones) == 8'h00);
  wire unused_taps = ^div_taps;

  // prescaler free running; divide-by-2^n from its low bits
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prescale_reg <= 7'h00;
    end else begin
      prescale_reg <= prescale_reg + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // main timer
  // ----------------------------------------------------------------
  wire center_mode = timer_control_reg[TC_MAIN_CENTER];
  // a period value of zero would give a one-tick period, so clamp
  wire [MAIN_W-1:0] main_pv = (main_period_value < MIN_PERIOD_VALUE) ?
                              MIN_PERIOD_VALUE : main_period_value;
  wire main_at_period = (main_timer >= main_pv);
  wire main_at_zero = (main_timer == '0);

  // edge: wrap at period center: reverse at period
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      main_timer <= '0;
      main_down_reg <= 1'b0;
    end else if (!timer_control_reg[TC_MAIN_RUN]) begin
      main_timer <= '0;
      main_down_reg <= 1'b0;
    end else if (main_tick) begin
      if (!center_mode) begin
        main_down_reg <= 1'b0;
        main_timer <= main_at_period ? '0 : main_timer + 1'b1;
      end else if (!main_down_reg) begin
        if (main_at_period) begin
          main_down_reg <= 1'b1;
          main_timer <= main_timer - 1'b1;
        end else begin
          main_timer <= main_timer + 1'b1;
        end
      end else begin
        if (main_timer <= 1) begin
          main_down_reg <= 1'b0;
        end
        main_timer <= main_at_zero ? main_timer + 1'b1 :
                      main_timer - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel state: edge and center mode
  // ----------------------------------------------------------------
  // compl compares against timer + offset; the sum is one bit wider
  // so a compare above period+offset never matches (0% duty)
  wire [MAIN_W:0] shifted_timer = {1'b0, main_timer} +
                                  {1'b0, edge_offset_value};
  logic [2:0] prim_next;
  logic [2:0] compl_next;
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      wire [MAIN_W:0] cv = {1'b0, channel_compare_value[ch]};
      wire prim_hit = ({1'b0, main_timer} == cv);
      wire compl_hit = (shifted_timer == cv);
      // edge mode looks one count ahead, so the output is active from
      // the count equal to cv on and duty is 1 - cv/(pv+1)
      wire prim_step = (({1'b0, main_timer} + 1'b1) == cv);
      wire compl_step = ((shifted_timer + 1'b1) == cv);
      // edge mode: active from match until period wrap
      // center mode: active on up-match, passive on down-match
      always_comb begin
        prim_next[ch] = prim_state_reg[ch];
        compl_next[ch] = compl_state_reg[ch];
        if (!center_mode) begin
          if (main_at_period) begin
            prim_next[ch] = 1'b0;
            compl_next[ch] = 1'b0;
          end else begin
            if (prim_step) prim_next[ch] = 1'b1;
            if (compl_step) compl_next[ch] = 1'b1;
          end
          // compare of zero / equal to offset: active from start
          if (main_at_period && cv == 0) prim_next[ch] = 1'b1;
          if (main_at_period && cv == {1'b0, edge_offset_value})
            compl_next[ch] = 1'b1;
        end else begin
          if (prim_hit) prim_next[ch] = ~main_down_reg;
          if (compl_hit) compl_next[ch] = ~main_down_reg;
          if (main_at_zero && cv == 0) prim_next[ch] = 1'b1;
          if (main_at_zero && cv == {1'b0, edge_offset_value})
            compl_next[ch] = 1'b1;
        end
      end
    end
  endgenerate

  // channel flops advance on main ticks only
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prim_state_reg <= 3'h0;
      compl_state_reg <= 3'h0;
    end else if (!timer_control_reg[TC_MAIN_RUN]) begin
      prim_state_reg <= 3'h0;
      compl_state_reg <= 3'h0;
    end else if (main_tick) begin
      prim_state_reg <= prim_next;
      compl_state_reg <= compl_next;
    end
  end

  // ----------------------------------------------------------------
  // modulator channel: edge mode only, single output
  // ----------------------------------------------------------------
  wire [MOD_W-1:0] mod_pv = (timer_period_value == '0) ?
                            {{(MOD_W-1){1'b0}}, 1'b1} :
                            timer_period_value;
  wire mod_at_period = (modulator_timer >= mod_pv);

  // edge-aligned counting only; no offset, no center mode
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modulator_timer <= '0;
      mod_state_reg <= 1'b0;
    end else if (!timer_control_reg[TC_MOD_RUN]) begin
      modulator_timer <= '0;
      mod_state_reg <= 1'b0;
    end else if (mod_tick) begin
      modulator_timer <= mod_at_period ? '0 : modulator_timer + 1'b1;
      if (mod_at_period) begin
        mod_state_reg <= (modulator_compare_value == '0);
      end else if (({1'b0, modulator_timer} + 1'b1) ==
                   {1'b0, modulator_compare_value}) begin
        mod_state_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // output level logic
  // ----------------------------------------------------------------
  wire mod_sig = mod_state_reg ^ timer_control_reg[TC_MOD_INVERT];
  logic [2:0] prim_act;
  logic [2:0] compl_act;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_out
      wire [2:0] sel = mode_select_reg[4*ch +: 3];
      wire burst = mode_select_reg[4*ch + MS_BURST_BIT];
      wire prim_en = (sel == DOP_SEL_PRIMARY) || (sel == DOP_SEL_BOTH);
      wire compl_en = (sel == DOP_SEL_COMPL) || (sel == DOP_SEL_BOTH);
      // primary never burst gated
      assign prim_act[ch] = prim_en & prim_state_reg[ch];
      assign compl_act[ch] = compl_en & compl_state_reg[ch] &
                             (~burst | mod_sig);
    end
  endgenerate
  wire mod_act = timer_control_reg[TC_MOD_OUT_EN] & mod_state_reg;
  // active level is inverted passive level; levels apply live
  wire [6:0] act_vec = {mod_act, compl_act, prim_act};
  wire [6:0] level_vec = act_vec ^ output_level_control;
  wire trapped = timer_control_reg[TC_TRAP_EN] & ~trap_n_i;
  wire [6:0] pin_vec = trapped ? trap_level_i : level_vec;

  // one register stage on the pins keeps them glitch free
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pin_vec;
    end
  end
  assign pins_o = pins_reg;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_control_reg <= RST_TIMER_CONTROL;
      mode_select_reg <= RST_MODE_SELECT;
      output_level_control <= RST_OUTPUT_LEVEL;
      main_period_value <= RST_MAIN_PERIOD;
      edge_offset_value <= '0;
      channel_compare_value <= '{default: '0};
      timer_period_value <= RST_MOD_PERIOD;
      modulator_compare_value <= '0;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_TIMER_CONTROL: timer_control_reg <= wdata_i;
        ADDR_MODE_SELECT: mode_select_reg <= wdata_i[11:0];
        ADDR_OUTPUT_LEVEL: output_level_control <= wdata_i[6:0];
        ADDR_MAIN_PERIOD: main_period_value <= wdata_i;
        ADDR_EDGE_OFFSET: edge_offset_value <= wdata_i;
        ADDR_CMP0: channel_compare_value[0] <= wdata_i;
        ADDR_CMP1: channel_compare_value[1] <= wdata_i;
        ADDR_CMP2: channel_compare_value[2] <= wdata_i;
        ADDR_MOD_PERIOD: timer_period_value <= wdata_i[MOD_W-1:0];
        ADDR_MOD_COMPARE: modulator_compare_value <= wdata_i[MOD_W-1:0];
        default: ; // timers and status are read only
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000; // unmapped reads return zero
    case (addr_i)
      ADDR_TIMER_CONTROL: rd_mux = timer_control_reg;
      ADDR_MODE_SELECT: rd_mux = {4'h0, mode_select_reg};
      ADDR_OUTPUT_LEVEL: rd_mux = {9'h000, output_level_control};
      ADDR_MAIN_PERIOD: rd_mux = main_period_value;
      ADDR_EDGE_OFFSET: rd_mux = edge_offset_value;
      ADDR_CMP0: rd_mux = channel_compare_value[0];
      ADDR_CMP1: rd_mux = channel_compare_value[1];
      ADDR_CMP2: rd_mux = channel_compare_value[2];
      ADDR_MOD_PERIOD: rd_mux = {6'h00, timer_period_value};
      ADDR_MOD_COMPARE: rd_mux = {6'h00, modulator_compare_value};
      ADDR_MAIN_TIMER: rd_mux = main_timer;
      ADDR_MOD_TIMER: rd_mux = {6'h00, modulator_timer};
      ADDR_STATUS: rd_mux = {6'h00, unused_taps & 1'b0, main_down_reg,
                             trapped, mod_state_reg, compl_state_reg,
                             prim_state_reg[2:1], prim_state_reg[0]};
      default: rd_mux = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rd_i ? rd_mux : 16'h0000;
    end
  end
  assign rdata_o = rdata_reg;
endmodule

// ---- test/dop_unit_checker.sv ----
// checker: port level relations of the dual output pwm unit
`timescale 1ns/1ps
module dop_unit_checker
  import dop_pkg::*;
#(
  parameter int MAIN_W = 16, // main timer width
  parameter int MOD_W = 10 // modulator timer width
) (
  input wire logic core_clk_i, // clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [3:0] addr_i, // register index
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [15:0] rdata_o, // read data
  input wire logic trap_n_i, // emergency input, active low
  input wire logic [6:0] trap_level_i, // trap levels
  input wire dop_pins_t pins_o // pwm pins
);
  // ------------------------------------------------------------
  // snooped configuration
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic [11:0] tc_q; // timer control copy
  logic [11:0] ms_q; // mode select copy
  logic [6:0] ol_q; // output level copy
  // a config write makes the next pin value a transition, not a rule
  wire cfg_wr = wr_i && (addr_i <= ADDR_OUTPUT_LEVEL);
  wire quiet = !(tc_q[TC_TRAP_EN] && !trap_n_i); // no trap forcing
  wire idle = quiet && !tc_q[TC_MAIN_RUN] && !tc_q[TC_MOD_RUN];
  // copies follow writes at the same edge as the registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tc_q <= '0;
      ms_q <= '0;
      ol_q <= '0;
    end else if (wr_i && addr_i == ADDR_TIMER_CONTROL) begin
      tc_q <= wdata_i[11:0];
    end else if (wr_i && addr_i == ADDR_MODE_SELECT) begin
      ms_q <= wdata_i[11:0];
    end else if (wr_i && addr_i == ADDR_OUTPUT_LEVEL) begin
      ol_q <= wdata_i[6:0];
    end
  end
  // ------------------------------------------------------------
  // sequences and properties
  // ------------------------------------------------------------
  sequence s_calm(c);
    (c && !cfg_wr) ##1 c;
  endsequence
  sequence s_trap;
    (tc_q[TC_TRAP_EN] && !trap_n_i) ##1 (tc_q[TC_TRAP_EN] && !trap_n_i);
  endsequence
  sequence s_idle;
    (idle && !cfg_wr) [*2] ##1 idle;
  endsequence
  property p_ms_read;
    rd_i && addr_i == ADDR_MODE_SELECT |=> rdata_o[11:0] == $past(ms_q);
  endproperty
  a_ms_read: assert property (p_ms_read)
    else $error("mode select readback wrong");
  property p_ol_read;
    rd_i && addr_i == ADDR_OUTPUT_LEVEL |=> rdata_o[6:0] == $past(ol_q);
  endproperty
  a_ol_read: assert property (p_ol_read)
    else $error("output level readback wrong");
  property p_trap;
    s_trap |-> pins_o == $past(trap_level_i);
  endproperty
  a_trap: assert property (p_trap)
    else $error("pins not at trap level");
  property p_idle;
    s_idle |-> pins_o == ol_q;
  endproperty
  a_idle: assert property (p_idle)
    else $error("stopped pins not at passive level");
  property p_mod_off;
    s_calm(quiet && !tc_q[TC_MOD_OUT_EN]) |-> pins_o[6] == ol_q[OL_MOD_BIT];
  endproperty
  a_mod_off: assert property (p_mod_off)
    else $error("disabled modulator pin not passive");
  property p_sel_off;
    s_calm(quiet && ms_q[10:8] == 3'h0)
      |-> pins_o[2] == ol_q[2] && pins_o[5] == ol_q[5];
  endproperty
  a_sel_off: assert property (p_sel_off)
    else $error("unselected channel pins not passive");
  property p_prim_only;
    s_calm(quiet && ms_q[6:4] == 3'h1) |-> pins_o[4] == ol_q[4];
  endproperty
  a_prim_only: assert property (p_prim_only)
    else $error("complementary pin driven in primary mode");
  property p_timer_zero;
    rd_i && addr_i == ADDR_MAIN_TIMER && !tc_q[TC_MAIN_RUN]
      && !$past(tc_q[TC_MAIN_RUN]) |=> rdata_o == 16'h0000;
  endproperty
  a_timer_zero: assert property (p_timer_zero)
    else $error("stopped main timer not zero");
endmodule

// ---- test/dop_bridge_model.sv ----
// bridge switch model: counts conduction cycles of each gate
`timescale 1ns/1ps
module dop_bridge_model
  import dop_pkg::*;
(
  input wire logic clk_i, // gate sample clock
  input wire logic win_i, // count window
  input wire dop_pins_t gate_i, // gate drive, high turns switch on
  output logic [15:0] on_cnt_o [7] // on cycles per switch
);
  // ------------------------------------------------------------
  // conduction counters
  // ------------------------------------------------------------
  logic win_q; // window seen last cycle
  // counts restart as a window opens, so runs never mix
  always_ff @(posedge clk_i) begin
    win_q <= win_i;
    for (int i = 0; i < 7; i++) begin
      if (win_i && !win_q) begin
        on_cnt_o[i] <= 16'(gate_i[i]);
      end else if (win_i) begin
        on_cnt_o[i] <= on_cnt_o[i] + 16'(gate_i[i]);
      end
    end
  end
endmodule

// ---- test/dop_unit_test.sv ----
// testbench: register driven pwm scenarios for the dual output unit
`timescale 1ns/1ps
module dop_unit_test;
  import dop_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic core_clk_i = 1'b0; // 100 MHz clock
  logic resetn_i = 1'b0; // reset, active low
  logic [3:0] addr_i = 4'h0; // register index
  logic [15:0] wdata_i = 16'h0000; // write data
  logic wr_i = 1'b0; // write strobe
  logic rd_i = 1'b0; // read strobe
  logic trap_n_i = 1'b1; // emergency input, active low
  logic [6:0] trap_level_i = 7'h00; // trap levels
  logic win = 1'b0; // measure window
  logic [15:0] rdata_o; // read data
  dop_pins_t pins_o; // pwm pins
  logic [15:0] on_cnt [7]; // conduction counts
  int n_errors = 0; // mismatches
  int cmp_count = 0; // comparisons
  dop_unit dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .trap_n_i(trap_n_i),
    .trap_level_i(trap_level_i), .pins_o(pins_o));
  dop_bridge_model bridge_u (.clk_i(core_clk_i), .win_i(win),
    .gate_i(pins_o), .on_cnt_o(on_cnt));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, e, rdata_o);
  endtask
  // stop first, so a shorter period never strands a running timer
  task automatic cfg(input logic [15:0] pv, ov, c0, c1, c2);
    wr(ADDR_TIMER_CONTROL, 16'h0000);
    wr(ADDR_MAIN_PERIOD, pv);
    wr(ADDR_EDGE_OFFSET, ov);
    wr(ADDR_CMP0, c0);
    wr(ADDR_CMP1, c1);
    wr(ADDR_CMP2, c2);
  endtask
  // window spans whole periods, so phase does not matter
  task automatic meas(input int n, input logic [15:0] e [7]);
    repeat (30) @(posedge core_clk_i);
    win <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    win <= 1'b0;
    @(posedge core_clk_i);
    #1;
    for (int i = 0; i < 7; i++) begin
      chk($sformatf("pin %0d on cycles", i), e[i], on_cnt[i]);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    #1 chk("reset pins", 16'h0000, 16'(pins_o));
    rd(ADDR_MAIN_TIMER, 16'h0000, "main timer");
    rd(ADDR_MOD_TIMER, 16'h0000, "mod timer");
    rd(ADDR_MAIN_PERIOD, RST_MAIN_PERIOD, "main period");
    rd(ADDR_MOD_PERIOD, 16'(RST_MOD_PERIOD), "mod period");
    wr(ADDR_MAIN_TIMER, 16'h1234);
    rd(ADDR_MAIN_TIMER, 16'h0000, "read only timer");
    rd(4'hd, 16'h0000, "unmapped");
    wr(ADDR_OUTPUT_LEVEL, 16'h007f);
    repeat (3) @(posedge core_clk_i);
    #1 chk("passive high", 16'h007f, 16'(pins_o));
    rd(ADDR_OUTPUT_LEVEL, 16'h007f, "level reg");
    wr(ADDR_OUTPUT_LEVEL, 16'h0000);
    $display("test reset and levels done");
    // offset 2 stays below compare 3 and equals compare 2
    cfg(16'h0009, 16'h0002, 16'h0003, 16'h0002, 16'h000c);
    wr(ADDR_MODE_SELECT, 16'h0333);
    wr(ADDR_TIMER_CONTROL, 16'h0001);
    meas(100, '{70, 80, 0, 90, 100, 0, 0});
    wr(ADDR_OUTPUT_LEVEL, 16'h0001);
    meas(100, '{30, 80, 0, 90, 100, 0, 0});
    wr(ADDR_OUTPUT_LEVEL, 16'h0000);
    wr(ADDR_TIMER_CONTROL, 16'h0009);
    meas(160, '{112, 128, 0, 144, 160, 0, 0});
    $display("test edge aligned done");
    cfg(16'h0008, 16'h0002, 16'h0003, 16'h0002, 16'h000c);
    wr(ADDR_TIMER_CONTROL, 16'h0003);
    meas(160, '{100, 120, 0, 140, 160, 0, 0});
    $display("test center aligned done");
    cfg(16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h000c);
    wr(ADDR_TIMER_CONTROL, 16'h0001);
    meas(100, '{50, 0, 0, 50, 0, 0, 0});
    wr(ADDR_MOD_PERIOD, 16'h0004);
    wr(ADDR_MOD_COMPARE, 16'h0001);
    wr(ADDR_OUTPUT_LEVEL, 16'h0040);
    wr(ADDR_TIMER_CONTROL, 16'h0021);
    meas(100, '{50, 0, 0, 50, 0, 0, 100});
    wr(ADDR_TIMER_CONTROL, 16'h0221);
    meas(100, '{50, 0, 0, 50, 0, 0, 20});
    $display("test period floor and modulator done");
    cfg(16'h0009, 16'h0002, 16'h0003, 16'h0002, 16'h000c);
    wr(ADDR_MOD_COMPARE, 16'h000a);
    wr(ADDR_OUTPUT_LEVEL, 16'h0000);
    wr(ADDR_MODE_SELECT, 16'h001b);
    rd(ADDR_MODE_SELECT, 16'h001b, "mode select");
    wr(ADDR_TIMER_CONTROL, 16'h0021);
    meas(100, '{70, 80, 0, 0, 0, 0, 0});
    wr(ADDR_TIMER_CONTROL, 16'h0421);
    meas(100, '{70, 80, 0, 90, 0, 0, 0});
    $display("test burst done");
    trap_level_i <= 7'h55;
    wr(ADDR_TIMER_CONTROL, 16'h0821);
    trap_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1 chk("trap pins", 16'h0055, 16'(pins_o));
    @(posedge core_clk_i);
    trap_n_i <= 1'b1;
    $display("test trap done");
    finish_test();
  end
  // cut a hang well past the expected run of some 14 us
  initial begin
    #200us;
    n_errors++;
    finish_test();
  end
endmodule
bind dop_unit dop_unit_checker #(.MAIN_W(MAIN_W), .MOD_W(MOD_W)) chk_u (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .trap_n_i(trap_n_i), .trap_level_i(trap_level_i), .pins_o(pins_o));
